// *** rtl/sgl_pkg.sv ***
// Purpose: shared constants and types for the drive indicator register bank
// Assumes: eight drives in two banks, 20 MHz system clock
// Notes: register word byte 0 is bits 31:24, byte 3 is bits 7:0
// Functional notes
// - version field reads zero, writes ignored
// - enable gates link; disable waits stream end
// - config 0 shows three read-only counts
// - blink period is (code+1) eighths second
// - forced-off minimum is code eighths second
// - activity on limited to code quarter seconds
// - stretch-off minimum is code sixty-fourths
// - forced low uses longer of two off times
// - stretch-on minimum is (code+1) sixty-fourths
// - receive bank holds three bits per drive
// - transmit byte: activity, locate, fault fields
// - activity 000 low, 001 high
// - activity 010/011 blink A, 110/111 blink B
// - activity 100/101 pulse on end/start events
// - activity field resets to start tracking
// - locate field: low, high, blink A phases
// - fault field: low, high, blink A/B phases
// - stagger max-on toggling across drives
// - normal mode only, load pattern all zero
// - three input bits captured per drive
package sgl_pkg;
	// register types and indexes
	localparam logic [7:0] TYPE_CFG = 8'h00;
	localparam logic [7:0] TYPE_RX = 8'h01;
	localparam logic [7:0] TYPE_TX = 8'h03;
	localparam logic [7:0] IDX_CFG0 = 8'h00;
	localparam logic [7:0] IDX_CFG1 = 8'h01;
	localparam logic [7:0] IDX_BANK_LAST = 8'h01;
	localparam int NUM_DRV = 8;
	// config 0 layout and read-only values
	localparam int EN_BIT = 23;
	localparam int VER_LSB = 16;
	localparam int CFGCNT_LSB = 12;
	localparam int GPCNT_LSB = 8;
	localparam int DRVCNT_LSB = 0;
	localparam logic [3:0] VERSION = 4'h0;
	localparam logic [3:0] CFG_REG_TOTAL = 4'h2;
	localparam logic [3:0] raw_data_reg_total = 4'h0;
	localparam logic [7:0] DRV_TOTAL = 8'h08;
	// config 1 field positions and reset value
	localparam int RATE_B_LSB = 20;
	localparam int RATE_A_LSB = 16;
	localparam int FORCE_LSB = 12;
	localparam int MAXON_LSB = 8;
	localparam int SOFF_LSB = 4;
	localparam int SON_LSB = 0;
	localparam logic [31:0] CFG1_MASK = 32'h00ff_ffff;
	localparam logic [31:0] CFG1_RESET = 32'h0000_1200;
	// transmit byte layout and reset: start tracking, locate off, fault off
	localparam int ACT_LSB = 5;
	localparam int LOC_LSB = 3;
	localparam int ERR_LSB = 0;
	localparam logic [7:0] TX_BYTE_RESET = 8'ha0;
	localparam logic [3:0] SLOAD_NORMAL = 4'h0;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	// timing: one tick is 1/64 s
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_PERIOD_NS = 15625000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int BLINK_HALF_TICKS = 4;
	localparam int EIGHTH_TICKS = 8;
	localparam int QUARTER_TICKS = 16;
	// indicator codes
	typedef enum logic [2:0] {
		ACT_OFF = 3'h0, ACT_ON = 3'h1, ACT_BA = 3'h2, ACT_BA_N = 3'h3,
		ACT_EOF = 3'h4, ACT_SOF = 3'h5, ACT_BB = 3'h6, ACT_BB_N = 3'h7
	} sgl_act_t;
	// register request, answer and indicator carriers
	typedef struct packed {
		logic [7:0] reg_type;
		logic [7:0] reg_index;
		logic wr;
		logic rd;
		logic [31:0] wdata;
	} sgl_req_t;
	typedef struct packed {
		logic ack;
		logic fail;
		logic [31:0] rdata;
	} sgl_rsp_t;
	typedef struct packed {
		logic drive_activity_out_bit;
		logic drive_locate_out_bit;
		logic drive_fault_out_bit;
	} sgl_led_t;
endpackage

// *** rtl/sgl_tick_div.sv ***
// Purpose: divides the system clock to a one-cycle 1/64 s tick
// Assumes: TICK_CYCLES at least 2
// Notes: tick is a clock enable, not a clock
module sgl_tick_div #(
	parameter int TICK_CYCLES = sgl_pkg::TICK_CYCLES // cycles per tick
) (
	input wire logic clk_sys_i, // system clock
	input wire logic rst_b_i, // synchronous reset, active low
	output logic tick_o // one-cycle enable every tick period
);
	logic [19:0] cnt; // cycles since last tick
	logic [19:0] next_cnt;
	logic next_tick;

	// wrap counter and fire tick at the end of each period
	always_comb begin
		if (cnt == 20'(TICK_CYCLES - 1)) begin
			next_cnt = '0;
			next_tick = 1'b1;
		end else begin
			next_cnt = cnt + 20'h1;
			next_tick = 1'b0;
		end
	end

	// register counter and tick
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			cnt <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick_o <= next_tick;
		end
	end
endmodule // sgl_tick_div

// *** rtl/sgl_act_track.sv ***
// Purpose: shapes activity events into one drive's activity indicator
// Assumes: tick_i is the 1/64 s enable; settings are 4-bit codes
// Notes: hold counts load one extra tick to cover the partial first period
module sgl_act_track (
	input wire logic clk_sys_i, // system clock
	input wire logic rst_b_i, // synchronous reset, active low
	input wire logic tick_i, // 1/64 s enable
	input wire logic event_i, // selected start or end event pulse
	input wire logic [3:0] max_on_i, // maximum on, quarter seconds
	input wire logic [3:0] force_off_i, // forced off, eighth seconds
	input wire logic [3:0] soff_i, // stretch off, 1/64 s
	input wire logic [3:0] son_i, // stretch on, (code+1)/64 s
	input wire logic [1:0] jitter_i, // per-drive shortening of max on
	output logic active_o // shaped activity level
);
	typedef enum logic [1:0] {TRK_IDLE = 2'b00, TRK_LIT = 2'b01, TRK_DARK = 2'b11} sgl_trk_t;
	sgl_trk_t state, next_state; // tracker state
	logic [7:0] hold, next_hold; // ticks left in minimum phase
	logic [7:0] on_time, next_on_time; // ticks spent lit
	logic pend, next_pend; // event seen while held dark
	logic [7:0] limit; // max on in ticks, staggered
	logic [7:0] force_ticks; // forced off in ticks

	assign limit = 8'({max_on_i, 4'h0}) - 8'(jitter_i);
	assign force_ticks = 8'({1'b0, force_off_i, 3'h0});

	// state machine: idle, lit with stretch and limit, dark with minimum
	always_comb begin
		next_state = state;
		next_hold = hold;
		next_on_time = on_time;
		next_pend = pend;
		unique case (state)
			TRK_IDLE: begin
				if (event_i || pend) begin
					next_state = TRK_LIT;
					next_hold = 8'({4'h0, son_i}) + 8'h2;
					next_on_time = '0;
					next_pend = 1'b0;
				end
			end
			TRK_LIT: begin
				if (event_i) begin
					next_hold = 8'({4'h0, son_i}) + 8'h2; // retrigger keeps lit until max-on limit
				end else if (tick_i && hold != 8'h0) begin
					next_hold = hold - 8'h1;
				end
				if (tick_i) begin
					next_on_time = on_time + 8'h1;
				end
				if (tick_i && max_on_i != 4'h0 && on_time + 8'h1 >= limit) begin
					next_state = TRK_DARK;
					// longer of forced and stretch off
					next_hold = ((force_ticks > 8'(soff_i)) ? force_ticks : 8'(soff_i))
						+ 8'h1;
				end else if (!event_i && tick_i && hold <= 8'h1) begin
					next_state = TRK_DARK;
					next_hold = 8'(soff_i) + 8'h1;
				end
			end
			TRK_DARK: begin
				if (event_i) begin
					next_pend = 1'b1;
				end
				if (tick_i && hold != 8'h0) begin
					next_hold = hold - 8'h1;
				end
				if (hold == 8'h0) begin
					next_state = TRK_IDLE;
				end
			end
			default: begin
				next_state = TRK_IDLE;
			end
		endcase
	end

	// register tracker state
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			state <= TRK_IDLE;
			hold <= '0;
			on_time <= '0;
			pend <= 1'b0;
		end else begin
			state <= next_state;
			hold <= next_hold;
			on_time <= next_on_time;
			pend <= next_pend;
		end
	end

	assign active_o = (state == TRK_LIT);

	// a dark phase with time left must stay dark on the next cycle
	property p_dark_low;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		state == TRK_DARK && hold != 8'h0 |=> !active_o;
	endproperty
	a_dark_low: assert property (p_dark_low) else $error("dark phase cut short");

	property p_min_on;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		$rose(active_o) |-> active_o [*8];
	endproperty
	a_min_on: assert property (p_min_on) else $error("activity pulse too short");

	property p_force_hold;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		(state == TRK_LIT && tick_i && max_on_i != 4'h0 && on_time + 8'h1 >= limit)
			|=> state == TRK_DARK && hold > $past(force_ticks) && hold > 8'($past(soff_i));
	endproperty
	a_force_hold: assert property (p_force_hold) else $error("forced off too short");
endmodule // sgl_act_track

// *** rtl/sgl_led_regs.sv ***
// Purpose: register bank and per-drive indicator patterns of a serial GPIO initiator
// Assumes: shift engine on clk_sys_i supplies stream status, input bits and frame events
// Notes: indicator and answer outputs are registered; one 1/64 s tick paces all timing
module sgl_led_regs #(
	parameter int TICK_CYCLES = sgl_pkg::TICK_CYCLES // cycles per 1/64 s tick
) (
	input wire logic clk_sys_i, // system clock, 20 MHz
	input wire logic rst_b_i, // synchronous reset, active low
	input wire sgl_pkg::sgl_req_t reg_req_i, // register read or write request
	output sgl_pkg::sgl_rsp_t reg_rsp_o, // answer, one cycle after request
	input wire logic link_clk_i, // serial link clock pin level
	input wire logic stream_busy_i, // bit stream in progress
	input wire logic rx_capture_i, // input bits of a stream are complete
	input wire logic [sgl_pkg::NUM_DRV-1:0][2:0] drive_input_bit_i, // received bits
	input wire logic [sgl_pkg::NUM_DRV-1:0] sof_i, // start of activity pulses
	input wire logic [sgl_pkg::NUM_DRV-1:0] eof_i, // end of activity pulses
	output logic gpio_enable_o, // link outputs and inputs active
	output logic [3:0] sload_pattern_o, // load pattern for each stream
	output sgl_pkg::sgl_led_t [sgl_pkg::NUM_DRV-1:0] led_o // per-drive output bits
);
	localparam int NDRV = sgl_pkg::NUM_DRV; // drive count

	// link clock synchroniser
	logic [2:0] lk_sync, next_lk_sync; // [0] first, [2] third stage
	logic lk_level, next_lk_level; // agreed link clock level

	// configuration state
	logic cfg_en, next_cfg_en; // software enable request
	logic [31:0] cfg1, next_cfg1; // timing settings word
	logic en_state, next_en_state; // effective enable
	logic [NDRV-1:0][7:0] tx_byte, next_tx_byte; // one transmit byte per drive
	logic [NDRV-1:0][2:0] rx_bits, next_rx_bits; // captured input bits
	sgl_pkg::sgl_rsp_t rsp, next_rsp; // register answer

	// timing state
	logic tick; // 1/64 s enable
	logic [1:0][6:0] blk_cnt, next_blk_cnt; // ticks in current half-cycle
	logic [1:0] blk_phase, next_blk_phase; // 1 = first half-cycle
	logic [15:0] lfsr, next_lfsr; // stagger source
	logic [NDRV-1:0] trk_act; // shaped activity per drive
	logic [NDRV-1:0] trk_event; // selected event per drive
	sgl_pkg::sgl_led_t [NDRV-1:0] led, next_led; // indicator bits

	// config 0 image, counts are constants
	logic [31:0] cfg0_word;
	assign cfg0_word = (32'(cfg_en) << sgl_pkg::EN_BIT)
		| (32'(sgl_pkg::VERSION) << sgl_pkg::VER_LSB)
		| (32'(sgl_pkg::CFG_REG_TOTAL) << sgl_pkg::CFGCNT_LSB)
		| (32'(sgl_pkg::raw_data_reg_total) << sgl_pkg::GPCNT_LSB)
		| (32'(sgl_pkg::DRV_TOTAL) << sgl_pkg::DRVCNT_LSB);

	// timing fields
	logic [3:0] rate_a, rate_b, force_off, max_on, soff, son;
	assign rate_a = cfg1[sgl_pkg::RATE_A_LSB +: 4];
	assign rate_b = cfg1[sgl_pkg::RATE_B_LSB +: 4];
	assign force_off = cfg1[sgl_pkg::FORCE_LSB +: 4];
	assign max_on = cfg1[sgl_pkg::MAXON_LSB +: 4];
	assign soff = cfg1[sgl_pkg::SOFF_LSB +: 4];
	assign son = cfg1[sgl_pkg::SON_LSB +: 4];

	// tick divider
	sgl_tick_div #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.tick_o(tick)
	);

	// link clock: three stages, level changes once stages two and three agree
	always_comb begin
		next_lk_sync = {lk_sync[1:0], link_clk_i};
		next_lk_level = (lk_sync[1] == lk_sync[2]) ? lk_sync[2] : lk_level;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			lk_sync <= '0;
			lk_level <= 1'b0;
		end else begin
			lk_sync <= next_lk_sync;
			lk_level <= next_lk_level;
		end
	end

	// effective enable: on at once, off only after the stream ends
	always_comb begin
		next_en_state = en_state;
		if (cfg_en) begin
			next_en_state = 1'b1;
		end else if (!stream_busy_i && !lk_level) begin
			next_en_state = 1'b0; // stream done, link clock in low phase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			en_state <= 1'b0;
		end else begin
			en_state <= next_en_state;
		end
	end

	assign gpio_enable_o = en_state;
	assign sload_pattern_o = sgl_pkg::SLOAD_NORMAL;

	// register access and input capture
	always_comb begin
		next_cfg_en = cfg_en;
		next_cfg1 = cfg1;
		next_tx_byte = tx_byte;
		next_rsp = '0;
		// capture inputs only while the link is active
		next_rx_bits = (rx_capture_i && en_state) ? drive_input_bit_i : rx_bits;
		if (reg_req_i.wr || reg_req_i.rd) begin
			next_rsp.ack = 1'b1;
			unique case (reg_req_i.reg_type)
				sgl_pkg::TYPE_CFG: begin
					if (reg_req_i.reg_index == sgl_pkg::IDX_CFG0) begin
						next_rsp.rdata = cfg0_word;
						if (reg_req_i.wr) begin
							next_cfg_en = reg_req_i.wdata[sgl_pkg::EN_BIT];
						end
					end else if (reg_req_i.reg_index == sgl_pkg::IDX_CFG1) begin
						next_rsp.rdata = cfg1;
						if (reg_req_i.wr) begin
							next_cfg1 = reg_req_i.wdata & sgl_pkg::CFG1_MASK;
						end
					end else begin
						next_rsp.fail = 1'b1; // unsupported index
					end
				end
				sgl_pkg::TYPE_RX: begin
					if (reg_req_i.reg_index <= sgl_pkg::IDX_BANK_LAST && !reg_req_i.wr) begin
						for (int k = 0; k < 4; k++) begin
							// lowest drive in the low byte, reserved bits zero
							next_rsp.rdata[8*k +: 8] =
								{5'h00, rx_bits[4*reg_req_i.reg_index[0] + k]};
						end
					end else begin
						next_rsp.fail = 1'b1; // read-only bank or bad index
					end
				end
				sgl_pkg::TYPE_TX: begin
					if (reg_req_i.reg_index <= sgl_pkg::IDX_BANK_LAST) begin
						// highest drive of the four in bits 31:24
						next_rsp.rdata = tx_byte[4*reg_req_i.reg_index[0] +: 4];
						if (reg_req_i.wr) begin
							next_tx_byte[4*reg_req_i.reg_index[0] +: 4] = reg_req_i.wdata;
						end
					end else begin
						next_rsp.fail = 1'b1; // bad index
					end
				end
				default: begin
					next_rsp.fail = 1'b1; // type not held by this block
				end
			endcase
		end
	end

	// register the bank and answer
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			cfg_en <= 1'b0;
			cfg1 <= sgl_pkg::CFG1_RESET;
			tx_byte <= {NDRV{sgl_pkg::TX_BYTE_RESET}};
			rx_bits <= '0;
			rsp <= '0;
		end else begin
			cfg_en <= next_cfg_en;
			cfg1 <= next_cfg1;
			tx_byte <= next_tx_byte;
			rx_bits <= next_rx_bits;
			rsp <= next_rsp;
		end
	end

	assign reg_rsp_o = rsp;

	// blink generators: half-cycle of (code+1)*4 ticks
	always_comb begin
		logic [6:0] half;
		half = '0;
		next_blk_cnt = blk_cnt;
		next_blk_phase = blk_phase;
		for (int g = 0; g < 2; g++) begin
			half = {1'b0, (g == 0) ? rate_a : rate_b, 2'b00} + 7'(sgl_pkg::BLINK_HALF_TICKS);
			if (tick) begin
				if (blk_cnt[g] + 7'h1 >= half) begin
					next_blk_cnt[g] = '0;
					next_blk_phase[g] = ~blk_phase[g];
				end else begin
					next_blk_cnt[g] = blk_cnt[g] + 7'h1;
				end
			end
		end
	end

	// stagger source steps once per tick
	always_comb begin
		next_lfsr = lfsr;
		if (tick) begin
			next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			blk_cnt <= '0;
			blk_phase <= 2'b11;
			lfsr <= sgl_pkg::LFSR_SEED;
		end else begin
			blk_cnt <= next_blk_cnt;
			blk_phase <= next_blk_phase;
			lfsr <= next_lfsr;
		end
	end

	// one activity tracker per drive
	generate
		for (genvar d = 0; d < NDRV; d++) begin : g_trk
			// end code follows end events, every other code start events
			assign trk_event[d] = (tx_byte[d][sgl_pkg::ACT_LSB +: 3] == sgl_pkg::ACT_EOF)
				? eof_i[d] : sof_i[d];
			sgl_act_track u_trk (
				.clk_sys_i(clk_sys_i),
				.rst_b_i(rst_b_i),
				.tick_i(tick),
				.event_i(trk_event[d]),
				.max_on_i(max_on),
				.force_off_i(force_off),
				.soff_i(soff),
				.son_i(son),
				.jitter_i(lfsr[2*d +: 2]),
				.active_o(trk_act[d])
			);
		end
	endgenerate

	// indicator pattern selection per drive
	always_comb begin
		sgl_pkg::sgl_act_t act;
		logic [1:0] loc;
		logic [2:0] err;
		act = sgl_pkg::ACT_OFF;
		loc = '0;
		err = '0;
		next_led = led;
		for (int d = 0; d < NDRV; d++) begin
			act = sgl_pkg::sgl_act_t'(tx_byte[d][sgl_pkg::ACT_LSB +: 3]);
			loc = tx_byte[d][sgl_pkg::LOC_LSB +: 2];
			err = tx_byte[d][sgl_pkg::ERR_LSB +: 3];
			unique case (act)
				sgl_pkg::ACT_OFF: next_led[d].drive_activity_out_bit = 1'b0;
				sgl_pkg::ACT_ON: next_led[d].drive_activity_out_bit = 1'b1;
				sgl_pkg::ACT_BA: next_led[d].drive_activity_out_bit = blk_phase[0];
				sgl_pkg::ACT_BA_N: next_led[d].drive_activity_out_bit = ~blk_phase[0];
				sgl_pkg::ACT_EOF,
				sgl_pkg::ACT_SOF: next_led[d].drive_activity_out_bit = trk_act[d];
				sgl_pkg::ACT_BB: next_led[d].drive_activity_out_bit = blk_phase[1];
				sgl_pkg::ACT_BB_N: next_led[d].drive_activity_out_bit = ~blk_phase[1];
			endcase
			unique case (loc)
				2'h0: next_led[d].drive_locate_out_bit = 1'b0;
				2'h1: next_led[d].drive_locate_out_bit = 1'b1;
				2'h2: next_led[d].drive_locate_out_bit = blk_phase[0];
				2'h3: next_led[d].drive_locate_out_bit = ~blk_phase[0];
			endcase
			unique case (err)
				3'h0: next_led[d].drive_fault_out_bit = 1'b0;
				3'h1: next_led[d].drive_fault_out_bit = 1'b1;
				3'h2: next_led[d].drive_fault_out_bit = blk_phase[0];
				3'h3: next_led[d].drive_fault_out_bit = ~blk_phase[0];
				3'h4,
				3'h5: next_led[d].drive_fault_out_bit = 1'b0;
				3'h6: next_led[d].drive_fault_out_bit = blk_phase[1];
				3'h7: next_led[d].drive_fault_out_bit = ~blk_phase[1];
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			led <= '0;
		end else begin
			led <= next_led;
		end
	end

	assign led_o = led;

	// checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence s_cfg0_rd;
		reg_req_i.rd && !reg_req_i.wr && reg_req_i.reg_type == sgl_pkg::TYPE_CFG
			&& reg_req_i.reg_index == sgl_pkg::IDX_CFG0;
	endsequence
	sequence s_tx1_wr;
		reg_req_i.wr && reg_req_i.reg_type == sgl_pkg::TYPE_TX && reg_req_i.reg_index == 8'h01;
	endsequence
	sequence s_tx1_rd;
		reg_req_i.rd && !reg_req_i.wr && reg_req_i.reg_type == sgl_pkg::TYPE_TX
			&& reg_req_i.reg_index == 8'h01;
	endsequence

	property p_version;
		s_cfg0_rd |=> reg_rsp_o.ack && reg_rsp_o.rdata[sgl_pkg::VER_LSB +: 4] == 4'h0;
	endproperty
	a_version: assert property (p_version) else $error("version not zero");

	property p_counts;
		s_cfg0_rd |=> reg_rsp_o.rdata[15:0] == 16'h2008 && !reg_rsp_o.fail;
	endproperty
	a_counts: assert property (p_counts) else $error("config counts wrong");

	property p_defer_off;
		$fell(gpio_enable_o) |-> !$past(stream_busy_i) && !$past(cfg_en);
	endproperty
	a_defer_off: assert property (p_defer_off) else $error("disabled mid stream");

	property p_tx_back;
		s_tx1_wr ##1 s_tx1_rd |=> reg_rsp_o.rdata == $past(reg_req_i.wdata, 2);
	endproperty
	a_tx_back: assert property (p_tx_back) else $error("transmit bank readback");

	property p_rx_map;
		rx_capture_i && gpio_enable_o ##1 (reg_req_i.rd && !reg_req_i.wr
			&& reg_req_i.reg_type == sgl_pkg::TYPE_RX && reg_req_i.reg_index == 8'h00)
			|=> reg_rsp_o.rdata[2:0] == $past(drive_input_bit_i[0], 2)
			&& reg_rsp_o.rdata[31:27] == 5'h00;
	endproperty
	a_rx_map: assert property (p_rx_map) else $error("receive bank mapping");

	property p_act_off;
		tx_byte[0][7:5] == 3'h0 |=> !led_o[0].drive_activity_out_bit;
	endproperty
	a_act_off: assert property (p_act_off) else $error("activity not low");

	property p_act_blink;
		tx_byte[5][7:5] == 3'h3 |=> led_o[5].drive_activity_out_bit == !$past(blk_phase[0]);
	endproperty
	a_act_blink: assert property (p_act_blink) else $error("activity blink A phase");

	property p_loc_on;
		tx_byte[1][4:3] == 2'h1 |=> led_o[1].drive_locate_out_bit;
	endproperty
	a_loc_on: assert property (p_loc_on) else $error("locate not high");

	property p_err_gen_b;
		tx_byte[3][2:0] == 3'h7 |=> led_o[3].drive_fault_out_bit == !$past(blk_phase[1]);
	endproperty
	a_err_gen_b: assert property (p_err_gen_b) else $error("fault blink B phase");

	property p_err_odd;
		tx_byte[3][2:1] == 2'h2 |=> !led_o[3].drive_fault_out_bit;
	endproperty
	a_err_odd: assert property (p_err_odd) else $error("fault codes 4 and 5 not low");

	property p_blink_tick;
		$changed(blk_phase[0]) |-> $past(tick);
	endproperty
	a_blink_tick: assert property (p_blink_tick) else $error("blink moved off tick");

	property p_sload;
		sload_pattern_o == 4'h0;
	endproperty
	a_sload: assert property (p_sload) else $error("load pattern not zero");
endmodule // sgl_led_regs

// *** bench/sgl_target_model.sv ***
// Purpose: backplane target stand-in driving link clock, stream status and input bits
// Assumes: link clock period 400 ns, held low between frames
// Notes: outside a capture the input bits show the inverse of the last value
module sgl_target_model (
	input wire logic clk_sys_i, // system clock
	output logic link_clk_o, // link clock, low when idle
	output logic busy_o, // stream in progress
	output logic cap_o, // input bits valid pulse
	output logic [7:0][2:0] bits_o // per-drive input bits
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle state at time zero
	initial begin
		link_clk_o = 1'b0;
		busy_o = 1'b0;
		cap_o = 1'b0;
		bits_o = '0;
	end
	// one frame of four link periods, three bits per drive at the end
	task automatic frame(input logic [7:0][2:0] v);
		@(negedge clk_sys_i) busy_o = 1'b1;
		repeat (8) begin
			repeat (4) @(negedge clk_sys_i);
			link_clk_o = ~link_clk_o;
		end
		cap_o = 1'b1;
		bits_o = v;
		@(negedge clk_sys_i) cap_o = 1'b0;
		bits_o = ~v;
		busy_o = 1'b0;
	endtask
endmodule // sgl_target_model

// *** bench/sgl_led_regs_tb.sv ***
// Purpose: self-checking bench for the drive indicator register bank
// Assumes: tick shortened to 8 cycles, so a blink half cycle is 32 cycles
// Notes: inputs change at the falling clock edge
module sgl_led_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i, rst_b_i, link_clk, busy, cap, en_o;
	sgl_pkg::sgl_req_t req;
	sgl_pkg::sgl_rsp_t rsp, ans;
	logic [7:0][2:0] bits;
	logic [7:0] sof, eof;
	logic [3:0] sload;
	sgl_pkg::sgl_led_t [7:0] led, a;
	int n_mismatch, check_count, cyc, lo;
	sgl_led_regs #(.TICK_CYCLES(8)) i_sgl_led_regs (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.reg_req_i(req), .reg_rsp_o(rsp), .link_clk_i(link_clk), .stream_busy_i(busy),
		.rx_capture_i(cap), .drive_input_bit_i(bits), .sof_i(sof), .eof_i(eof),
		.gpio_enable_o(en_o), .sload_pattern_o(sload), .led_o(led));
	sgl_target_model i_sgl_target_model (.clk_sys_i(clk_sys_i), .link_clk_o(link_clk),
		.busy_o(busy), .cap_o(cap), .bits_o(bits));
	// clock and hang guard
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic check(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one access: held one cycle, answer kept while it stands, then one idle cycle
	task automatic rw(input logic w, input logic [7:0] t, ix, input logic [31:0] d);
		@(negedge clk_sys_i) req = '{t, ix, w, ~w, d};
		@(negedge clk_sys_i) req = '0;
		ans = rsp;
		check(32'(ans.ack), 32'h1);
		@(negedge clk_sys_i);
	endtask
	task automatic rd(input logic [7:0] t, ix, input logic [31:0] e);
		rw(1'b0, t, ix, 32'h0);
		check(ans.rdata, e);
	endtask
	task automatic t_reset;
		rd(8'h00, 8'h00, 32'h0000_2008);
		rd(8'h00, 8'h01, 32'h0000_1200);
		rd(8'h03, 8'h00, 32'ha0a0_a0a0);
		check(32'(sload), 32'h0);
		$display("reset test done");
	endtask
	task automatic t_cfg;
		rw(1'b1, 8'h00, 8'h00, 32'hffff_ffff);
		rd(8'h00, 8'h00, 32'h0080_2008);
		check(32'(en_o), 32'h1);
		$display("config test done");
	endtask
	// unsupported type, write to receive bank, indexes out of range
	task automatic t_refuse;
		logic [7:0] tt[4] = '{8'h02, 8'h01, 8'h00, 8'h03};
		logic [7:0] ti[4] = '{8'h00, 8'h00, 8'h02, 8'h02};
		for (int k = 0; k < 4; k++) begin
			rw(k[0], tt[k], ti[k], 32'hffff_ffff);
			check(32'(ans.fail), 32'h1);
		end
		rd(8'h01, 8'h00, 32'h0);
		$display("refuse test done");
	endtask
	task automatic t_rx;
		logic [7:0][2:0] v;
		for (int k = 0; k < 8; k++) v[k] = 3'(k);
		// first read lands on the edge right after the capture
		fork
			i_sgl_target_model.frame(v);
			begin
				@(posedge cap);
				rd(8'h01, 8'h00, 32'h0302_0100);
			end
		join
		rd(8'h01, 8'h01, 32'h0706_0504);
		$display("receive test done");
	endtask
	// drive0 act on, drive1 locate on, drive2 fault on, drive3 fault code 100
	task automatic t_tx;
		rw(1'b1, 8'h03, 8'h00, 32'h0401_0820);
		check(32'(led[3:0]), 32'h0000_0054);
		// back-to-back write then read of bank 1
		@(negedge clk_sys_i) req = '{8'h03, 8'h01, 1'b1, 1'b0, 32'h1122_3344};
		@(negedge clk_sys_i) req = '{8'h03, 8'h01, 1'b0, 1'b1, 32'h0};
		@(negedge clk_sys_i) req = '0;
		check(rsp.rdata, 32'h1122_3344);
		$display("transmit test done");
	endtask
	// activity and locate blink codes pair against their opposite phase; fault blink A pairs against inverted blink B
	task automatic t_blink;
		rw(1'b1, 8'h03, 8'h00, 32'h0702_1810);
		rw(1'b1, 8'h03, 8'h01, 32'he0c0_6040);
		a = led;
		check(32'(a[4][2] ^ a[5][2]), 32'h1);
		check(32'(a[6][2] ^ a[7][2]), 32'h1);
		check(32'(a[0][1] ^ a[1][1]), 32'h1);
		check(32'(a[2][0] ^ a[3][0]), 32'h1);
		repeat (32) @(negedge clk_sys_i);
		check(32'(led), 32'(a ^ 24'h924252));
		$display("blink test done");
	endtask
	task automatic t_act;
		rw(1'b1, 8'h03, 8'h00, 32'h0000_80a0);
		@(negedge clk_sys_i) sof = 8'h03;
		@(negedge clk_sys_i) sof = 8'h00;
		@(negedge clk_sys_i) check(32'({led[1][2], led[0][2]}), 32'h1);
		@(negedge clk_sys_i) eof = 8'h02;
		@(negedge clk_sys_i) eof = 8'h00;
		@(negedge clk_sys_i) check(32'(led[1][2]), 32'h1);
		rw(1'b1, 8'h00, 8'h01, 32'h0000_1100);
		lo = 0;
		for (int k = 0; k < 240; k++) begin
			@(negedge clk_sys_i) sof[0] = (k % 4 == 0);
			lo += (led[0][2] === 1'b0);
		end
		check(32'(lo >= 64 && lo <= 84), 32'h1);
		$display("activity test done");
	endtask
	// disable waits for the stream in progress
	task automatic t_dis;
		fork
			i_sgl_target_model.frame('0);
			begin
				rw(1'b1, 8'h00, 8'h00, 32'h0);
				check(32'(en_o), 32'h1);
			end
		join
		repeat (8) @(negedge clk_sys_i);
		check(32'(en_o), 32'h0);
		// a frame while disabled must not be captured
		i_sgl_target_model.frame('1);
		rd(8'h01, 8'h00, 32'h0);
		$display("disable test done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		rst_b_i = 1'b0;
		req = '0;
		sof = '0;
		eof = '0;
		repeat (5) @(negedge clk_sys_i);
		rst_b_i = 1'b1;
		t_reset();
		t_cfg();
		t_refuse();
		t_rx();
		t_tx();
		t_blink();
		t_act();
		t_dis();
		test_done();
	end
endmodule // sgl_led_regs_tb
